// ===== logic/ddr2_pd_pkg.sv
// Shared constants and types for the command and power-state block
`default_nettype none
package ddr2_pd_pkg;

  // ------------------------------------------------------------------
  // Array geometry
  // ------------------------------------------------------------------
  localparam int BANK_COUNT = 4;
  localparam int BA_WIDTH   = 2;
  localparam int ROW_WIDTH  = 13;
  localparam int ROW_COUNT  = 8192;

  // ------------------------------------------------------------------
  // Timing figures and derived cycle counts
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int REFRESH_WINDOW_MS = 64;
  // Average refresh interval in ref_clk cycles, rounded down
  localparam int REFI_CYCLES =
    (REFRESH_WINDOW_MS * 1000000) / (ROW_COUNT * CLK_PERIOD_NS);
  localparam int MAX_PD_REFI       = 9;   // longest power-down stay
  localparam int FREQ_WAIT_CLOCKS  = 2;   // clocks after clock enable falls
  localparam int SELF_EXIT_READ_CLOCKS = 200;
  localparam int BURST_LENGTH      = 4;
  localparam int BURST_CLOCKS      = BURST_LENGTH / 2;
  localparam int MODE_SET_CLOCKS   = 2;   // mode register command time
  localparam int REFRESH_BUSY_CYCLES = 8; // internal refresh duration

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [BANK_COUNT-1:0] BANKS_RESET = 4'h0;
  localparam logic [ROW_WIDTH-1:0]  ROW_RESET   = 13'h0000;
  localparam logic [BA_WIDTH-1:0]   BANK_RESET  = 2'h0;

  // ------------------------------------------------------------------
  // Decoded commands and power states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_MODE_SET
  } cmd_type;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_PRECHARGE_DOWN,
    PWR_ACTIVE_DOWN,
    PWR_SELF_REFRESH
  } pwr_state_type;

endpackage : ddr2_pd_pkg
`default_nettype wire

// ===== logic/cmd_decode.sv
// Command decoder from the four strobe pins
`default_nettype none
module cmd_decode (
  // Strobes, active low
  input  wire logic               csN,
  input  wire logic               rasN,
  input  wire logic               casN,
  input  wire logic               weN,
  // Decoded command
  output ddr2_pd_pkg::cmd_type    cmd
);

  // ------------------------------------------------------------------
  // Truth table; deselect folds into no-operation
  // ------------------------------------------------------------------
  always_comb
  begin
    if (csN)
      cmd = ddr2_pd_pkg::CMD_NOP;
    else
    begin
      case ({rasN, casN, weN})
        3'b011:  cmd = ddr2_pd_pkg::CMD_ACTIVATE;
        3'b101:  cmd = ddr2_pd_pkg::CMD_READ;
        3'b100:  cmd = ddr2_pd_pkg::CMD_WRITE;
        3'b010:  cmd = ddr2_pd_pkg::CMD_PRECHARGE;
        3'b001:  cmd = ddr2_pd_pkg::CMD_REFRESH;
        3'b000:  cmd = ddr2_pd_pkg::CMD_MODE_SET;
        default: cmd = ddr2_pd_pkg::CMD_NOP;
      endcase
    end
  end

endmodule : cmd_decode
`default_nettype wire

// ===== logic/bank_tracker.sv
// Per-bank open-row tracking and burst completion
`default_nettype none
module bank_tracker #(
  parameter int BANKS = ddr2_pd_pkg::BANK_COUNT
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Accepted command, one pulse per memory clock edge
  input  wire logic                  cmdTake,
  input  wire ddr2_pd_pkg::cmd_type  cmd,
  input  wire logic [ddr2_pd_pkg::BA_WIDTH-1:0] bankSel,
  input  wire logic                  autoPre,
  input  wire logic                  memEdge,
  // State seen by the power logic
  output logic [BANKS-1:0]           bankOpen,
  output logic                       burstBusy
);

  logic [1:0]                        burstLeft_reg;
  logic                              apPending_reg;
  logic [ddr2_pd_pkg::BA_WIDTH-1:0]  apBank_reg;
  logic                              burstStart;
  logic                              burstEnd;

  assign burstStart = cmdTake && !burstBusy &&
                      (cmd == ddr2_pd_pkg::CMD_READ ||
                       cmd == ddr2_pd_pkg::CMD_WRITE);
  assign burstEnd   = memEdge && burstLeft_reg == 2'h1;
  assign burstBusy  = burstLeft_reg != 2'h0;

  // ------------------------------------------------------------------
  // Burst counter; a running burst is never cut short
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      burstLeft_reg <= 2'h0;
      apPending_reg <= 1'b0;
      apBank_reg    <= ddr2_pd_pkg::BANK_RESET;
    end
    else if (burstStart)
    begin
      burstLeft_reg <= 2'(ddr2_pd_pkg::BURST_CLOCKS);
      apPending_reg <= autoPre;
      apBank_reg    <= bankSel;
    end
    else if (memEdge && burstBusy)
      burstLeft_reg <= burstLeft_reg - 2'h1;
  end

  // ------------------------------------------------------------------
  // Open-row bit per bank
  // ------------------------------------------------------------------
  for (genvar b = 0; b < BANKS; b++)
  begin : gBank
    logic hit;
    assign hit = bankSel == ddr2_pd_pkg::BA_WIDTH'(b);
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        bankOpen[b] <= 1'b0;
      else if (cmdTake && cmd == ddr2_pd_pkg::CMD_ACTIVATE && hit)
        bankOpen[b] <= 1'b1;
      else if (cmdTake && cmd == ddr2_pd_pkg::CMD_PRECHARGE &&
               (autoPre || hit))
        bankOpen[b] <= 1'b0;
      else if (burstEnd && apPending_reg &&
               apBank_reg == ddr2_pd_pkg::BA_WIDTH'(b))
        bankOpen[b] <= 1'b0;
    end
  end

endmodule : bank_tracker
`default_nettype wire

// ===== logic/ddr2_refresh_powerdown_cmd.sv
// Command decode, refresh counter and power-down state of the memory
`default_nettype none
module ddr2_refresh_powerdown_cmd #(
  parameter int BANKS    = ddr2_pd_pkg::BANK_COUNT,
  parameter int ROW_BITS = ddr2_pd_pkg::ROW_WIDTH
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Memory pins from the controller
  input  wire logic                  memClk,
  input  wire logic                  clkEnable,
  input  wire logic                  csN,
  input  wire logic                  rasN,
  input  wire logic                  casN,
  input  wire logic                  weN,
  input  wire logic                  addrBit10,
  input  wire logic [ddr2_pd_pkg::BA_WIDTH-1:0] bankAddr,
  input  wire logic                  termEnable,
  // Configuration
  input  wire logic                  fastExitMode,
  // Command results
  output logic                       refreshStart,
  output logic                       refreshBusy,
  output logic [ddr2_pd_pkg::BA_WIDTH-1:0] refreshBank,
  output logic [ROW_BITS-1:0]        refreshRow,
  output logic                       modeWrite,
  output logic [ddr2_pd_pkg::BA_WIDTH-1:0] modeSelect,
  output logic [BANKS-1:0]           bankOpen,
  output logic                       burstBusy,
  // Power state
  output ddr2_pd_pkg::pwr_state_type powerState,
  output logic                       buffersOn,
  output logic                       dllOn,
  output logic                       freqChangeOk,
  output logic                       refreshOverdue,
  output logic                       readAllowed,
  output logic                       enableViolation
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam int SYNC_W = 9 + ddr2_pd_pkg::BA_WIDTH;

  logic [SYNC_W-1:0]  pinMeta_reg;
  logic [SYNC_W-1:0]  pinSync_reg;
  logic               clkLast_reg;
  logic               memRise;
  logic               ckeNow;
  logic               termNow;
  logic               a10Now;
  logic [ddr2_pd_pkg::BA_WIDTH-1:0] baNow;
  ddr2_pd_pkg::cmd_type cmdNow;
  logic               ckePrev_reg;
  logic               cmdTake;
  logic               nopNow;
  logic               allIdle;

  ddr2_pd_pkg::pwr_state_type state_reg;
  ddr2_pd_pkg::pwr_state_type state_next;

  logic [7:0]         refreshLeft_reg;
  logic [7:0]         refiCount_reg;
  logic               refiTick;
  logic [3:0]         pdIntervals_reg;
  logic [1:0]         lowEdges_reg;
  logic [7:0]         exitEdges_reg;
  logic [1:0]         modeLeft_reg;
  logic               internalRefresh;

  // ------------------------------------------------------------------
  // Pin synchronisers and memory clock edge detection
  // ------------------------------------------------------------------
  // Two stages before anything looks at a pin
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      clkLast_reg <= 1'b0;
    end
    else
    begin
      pinMeta_reg <= {memClk, clkEnable, csN, rasN, casN, weN,
                      addrBit10, bankAddr, termEnable, 1'b0};
      pinSync_reg <= pinMeta_reg;
      clkLast_reg <= pinSync_reg[SYNC_W-1];
    end
  end

  // Strobes are held around the edge, so the late sample is still valid
  assign memRise = pinSync_reg[SYNC_W-1] && !clkLast_reg;
  assign ckeNow  = pinSync_reg[SYNC_W-2];
  assign a10Now  = pinSync_reg[4];
  assign baNow   = pinSync_reg[3:2];
  assign termNow = pinSync_reg[1];

  cmd_decode uDecode (
    .csN  (pinSync_reg[SYNC_W-3]),
    .rasN (pinSync_reg[SYNC_W-4]),
    .casN (pinSync_reg[SYNC_W-5]),
    .weN  (pinSync_reg[SYNC_W-6]),
    .cmd  (cmdNow)
  );

  // Executable only with enable high on both edges and buffers alive
  assign nopNow  = cmdNow == ddr2_pd_pkg::CMD_NOP;
  assign cmdTake = memRise && ckePrev_reg && ckeNow &&
                   state_reg == ddr2_pd_pkg::PWR_RUN;

  bank_tracker #(
    .BANKS (BANKS)
  ) uBanks (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cmdTake   (cmdTake),
    .cmd       (cmdNow),
    .bankSel   (baNow),
    .autoPre   (a10Now),
    .memEdge   (memRise),
    .bankOpen  (bankOpen),
    .burstBusy (burstBusy)
  );

  assign allIdle = bankOpen == '0;

  // ------------------------------------------------------------------
  // Clock enable history, one entry per memory clock edge
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ckePrev_reg <= 1'b0;
    else if (memRise)
      ckePrev_reg <= ckeNow;
  end

  // ------------------------------------------------------------------
  // Power state machine
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ddr2_pd_pkg::PWR_RUN:
        if (memRise && ckePrev_reg && !ckeNow)
        begin
          if (cmdNow == ddr2_pd_pkg::CMD_REFRESH && allIdle)
            state_next = ddr2_pd_pkg::PWR_SELF_REFRESH;
          else if (nopNow && allIdle)
            state_next = ddr2_pd_pkg::PWR_PRECHARGE_DOWN;
          else if (nopNow)
            state_next = ddr2_pd_pkg::PWR_ACTIVE_DOWN;
        end
      ddr2_pd_pkg::PWR_PRECHARGE_DOWN,
      ddr2_pd_pkg::PWR_ACTIVE_DOWN:
        if (memRise && !ckePrev_reg && ckeNow && nopNow)
          state_next = ddr2_pd_pkg::PWR_RUN;
      ddr2_pd_pkg::PWR_SELF_REFRESH:
        // Clock may be stopped here, so no memory edge is awaited
        if (ckeNow && nopNow)
          state_next = ddr2_pd_pkg::PWR_RUN;
      default:
        state_next = ddr2_pd_pkg::PWR_RUN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_reg <= ddr2_pd_pkg::PWR_RUN;
    else
      state_reg <= state_next;
  end

  assign powerState = state_reg;

  // ------------------------------------------------------------------
  // Buffers and DLL follow the power state
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      buffersOn <= 1'b1;
      dllOn     <= 1'b1;
    end
    else
    begin
      buffersOn <= state_next == ddr2_pd_pkg::PWR_RUN;
      case (state_next)
        ddr2_pd_pkg::PWR_RUN:         dllOn <= 1'b1;
        ddr2_pd_pkg::PWR_ACTIVE_DOWN: dllOn <= fastExitMode;
        default:                      dllOn <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Auto refresh: internal address counter and busy time
  // ------------------------------------------------------------------
  // Self refresh steps the same counter on its own interval timer
  assign internalRefresh =
    refiTick && state_reg == ddr2_pd_pkg::PWR_SELF_REFRESH;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      refreshStart <= 1'b0;
      refreshBank  <= ddr2_pd_pkg::BANK_RESET;
      refreshRow   <= ROW_BITS'(ddr2_pd_pkg::ROW_RESET);
    end
    else
    begin
      refreshStart <= (cmdTake && cmdNow == ddr2_pd_pkg::CMD_REFRESH &&
                       allIdle) || internalRefresh;
      if ((cmdTake && cmdNow == ddr2_pd_pkg::CMD_REFRESH && allIdle) ||
          internalRefresh)
      begin
        // Address pins are never looked at here
        {refreshRow, refreshBank} <=
          {refreshRow, refreshBank} + 1'b1;
      end
    end
  end

  // Busy timer keeps running through power-down entry
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      refreshLeft_reg <= 8'h00;
    else if (refreshStart)
      refreshLeft_reg <= 8'(ddr2_pd_pkg::REFRESH_BUSY_CYCLES);
    else if (refreshLeft_reg != 8'h00)
      refreshLeft_reg <= refreshLeft_reg - 8'h01;
  end

  assign refreshBusy = refreshLeft_reg != 8'h00;

  // ------------------------------------------------------------------
  // Mode register writes and their command time
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      modeWrite    <= 1'b0;
      modeSelect   <= ddr2_pd_pkg::BANK_RESET;
      modeLeft_reg <= 2'h0;
    end
    else
    begin
      modeWrite <= cmdTake && cmdNow == ddr2_pd_pkg::CMD_MODE_SET;
      if (cmdTake && cmdNow == ddr2_pd_pkg::CMD_MODE_SET)
      begin
        modeSelect   <= baNow;
        modeLeft_reg <= 2'(ddr2_pd_pkg::MODE_SET_CLOCKS);
      end
      else if (memRise && modeLeft_reg != 2'h0)
        modeLeft_reg <= modeLeft_reg - 2'h1;
    end
  end

  // Enable dropped mid burst or mid mode set: flagged, and power-down is still entered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      enableViolation <= 1'b0;
    else
      enableViolation <= memRise && ckePrev_reg && !ckeNow &&
                         (burstBusy || modeLeft_reg != 2'h0);
  end

  // ------------------------------------------------------------------
  // Refresh interval timer and power-down stay limit
  // ------------------------------------------------------------------
  assign refiTick = refiCount_reg == 8'(ddr2_pd_pkg::REFI_CYCLES - 1);

  always_ff @(posedge ref_clk)
  begin
    if (rst || refiTick)
      refiCount_reg <= 8'h00;
    else
      refiCount_reg <= refiCount_reg + 8'h01;
  end

  // Counts whole intervals spent without refresh in power-down
  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg == ddr2_pd_pkg::PWR_RUN ||
        state_reg == ddr2_pd_pkg::PWR_SELF_REFRESH)
      pdIntervals_reg <= 4'h0;
    else if (refiTick && pdIntervals_reg != 4'hf)
      pdIntervals_reg <= pdIntervals_reg + 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      refreshOverdue <= 1'b0;
    else
      refreshOverdue <=
        pdIntervals_reg >= 4'(ddr2_pd_pkg::MAX_PD_REFI);
  end

  // ------------------------------------------------------------------
  // Frequency change window in precharge power-down
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg != ddr2_pd_pkg::PWR_PRECHARGE_DOWN)
      lowEdges_reg <= 2'h0;
    else if (memRise && !ckeNow && lowEdges_reg != 2'h3)
      lowEdges_reg <= lowEdges_reg + 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      freqChangeOk <= 1'b0;
    else
      freqChangeOk <= state_reg == ddr2_pd_pkg::PWR_PRECHARGE_DOWN &&
                      !termNow && !ckeNow &&
                      lowEdges_reg >= 2'(ddr2_pd_pkg::FREQ_WAIT_CLOCKS);
  end

  // ------------------------------------------------------------------
  // Read permission after self refresh exit
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      exitEdges_reg <= 8'(ddr2_pd_pkg::SELF_EXIT_READ_CLOCKS);
    else if (state_reg == ddr2_pd_pkg::PWR_SELF_REFRESH)
      exitEdges_reg <= 8'h00;
    else if (memRise &&
             exitEdges_reg != 8'(ddr2_pd_pkg::SELF_EXIT_READ_CLOCKS))
      exitEdges_reg <= exitEdges_reg + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      readAllowed <= 1'b1;
    else
      readAllowed <= exitEdges_reg ==
                     8'(ddr2_pd_pkg::SELF_EXIT_READ_CLOCKS);
  end

endmodule : ddr2_refresh_powerdown_cmd
`default_nettype wire

// ===== bench/mem_ctrl_model.sv
// Memory controller model driving the command pins
`default_nettype none
module mem_ctrl_model (
  // System clock
  input  wire logic       ref_clk,
  // Command pins
  output var  logic       memClk,
  output var  logic       clkEnable,
  output var  logic [3:0] cmdN,
  output var  logic       addrBit10,
  output var  logic [1:0] bankAddr,
  output var  logic       termEnable
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle pins; termination off and always at a valid level
  initial
  begin
    {clkEnable, cmdN} = 5'h1F;
    {memClk, addrBit10, bankAddr, termEnable} = 5'h00;
  end
  // Clock frames of 400 ns, pins held 4 ref_clk around each rise
  task automatic clk_cmd(input logic [3:0] c, input logic ce,
                         input logic a, input logic [1:0] ba,
                         input int n);
    // Called just after an edge; pins change together with the fall
    repeat (n)
    begin
      {cmdN, clkEnable, addrBit10, bankAddr} = {c, ce, a, ba};
      repeat (4) @(posedge ref_clk);
      #2;
      memClk = 1'b1;
      repeat (4) @(posedge ref_clk);
      #2;
      memClk = 1'b0;
    end
  endtask : clk_cmd
  // Pin change with no clock, for the asynchronous self refresh exit
  task automatic pins(input logic [3:0] c, input logic ce);
    @(posedge ref_clk);
    #2;
    cmdN = c;
    clkEnable = ce;
  endtask : pins
  // Termination level change, clock untouched
  task automatic set_term(input logic t);
    @(posedge ref_clk);
    #2;
    termEnable = t;
  endtask : set_term
endmodule : mem_ctrl_model
`default_nettype wire

// ===== bench/ddr2_refresh_powerdown_cmd_chk.sv
// Checker of the command and power-state block ports
`default_nettype none
module ddr2_refresh_powerdown_cmd_chk #(
  parameter int BANKS    = 4,
  parameter int ROW_BITS = 13
) (
  // Watched ports
  input  wire logic                ref_clk, rst, fastExitMode,
  input  wire logic                refreshStart, refreshBusy, modeWrite,
  input  wire logic [1:0]          refreshBank,
  input  wire logic [ROW_BITS-1:0] refreshRow,
  input  wire logic [BANKS-1:0]    bankOpen,
  input  wire ddr2_pd_pkg::pwr_state_type powerState,
  input  wire logic                buffersOn, dllOn, freqChangeOk,
  input  wire logic                readAllowed
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Refresh holds busy for its whole internal duration
  sequence busy_hold;
    refreshBusy [*8];
  endsequence
  AST_REF_PULSE: assert property (refreshStart |=>
    !refreshStart ##0 busy_hold) else $error("refresh pulse or busy bad");
  AST_REF_ADDR: assert property ($rose(refreshStart) |->
    {refreshRow, refreshBank} == $past({refreshRow, refreshBank}) + 1)
    else $error("refresh address did not step");
  // Buffers and DLL move on the same edge as the state itself
  AST_BUF: assert property (buffersOn ==
    (powerState == ddr2_pd_pkg::PWR_RUN)) else $error("buffers");
  AST_DLL: assert property (dllOn ==
    (powerState == ddr2_pd_pkg::PWR_RUN || ($past(fastExitMode) &&
    powerState == ddr2_pd_pkg::PWR_ACTIVE_DOWN))) else $error("dll");
  AST_PD_CLASS: assert property ($changed(powerState) &&
    $past(powerState) == ddr2_pd_pkg::PWR_RUN &&
    powerState != ddr2_pd_pkg::PWR_SELF_REFRESH |->
    (powerState == ddr2_pd_pkg::PWR_ACTIVE_DOWN) == (|bankOpen))
    else $error("power-down type wrong");
  AST_ONE_CMD: assert property (!(modeWrite && refreshStart))
    else $error("two commands at once");
  AST_FREQ: assert property (freqChangeOk |->
    powerState == ddr2_pd_pkg::PWR_PRECHARGE_DOWN ||
    $past(powerState) == ddr2_pd_pkg::PWR_PRECHARGE_DOWN)
    else $error("frequency change outside precharge power-down");
  AST_READ_GATE: assert property ($fell(readAllowed) |->
    $past(powerState) == ddr2_pd_pkg::PWR_SELF_REFRESH ||
    $past(powerState, 2) == ddr2_pd_pkg::PWR_SELF_REFRESH)
    else $error("read gate closed without self refresh exit");
endmodule : ddr2_refresh_powerdown_cmd_chk
`default_nettype wire

// ===== bench/ddr2_refresh_powerdown_cmd_tb.sv
// Testbench of the command and power-state block
`default_nettype none
module ddr2_refresh_powerdown_cmd_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst, fastExitMode, memClk, clkEnable, addrBit10;
  logic        termEnable, refreshStart, refreshBusy, modeWrite, dllOn;
  logic        buffersOn, freqChangeOk, refreshOverdue, readAllowed;
  logic        enableViolation, burstBusy;
  logic [3:0]  cmdN, bankOpen;
  logic [1:0]  bankAddr, refreshBank, modeSelect, lastSel;
  logic [12:0] refreshRow;
  ddr2_pd_pkg::pwr_state_type powerState;
  int          miscompares = 0, tests_run = 0, refs = 0, modes = 0;
  int          viols = 0;
  typedef struct {logic [3:0] c; logic a; logic [1:0] ba;
                  logic [3:0] open; int refs; int modes;} row_type;
  // Command, A10, bank, then open banks, refreshes, mode writes so far
  row_type rows[10] = '{'{7, 0, 0, 0, 0, 0}, '{1, 0, 0, 0, 1, 0},
    '{0, 0, 3, 0, 1, 1}, '{3, 0, 1, 2, 1, 1}, '{3, 0, 2, 6, 1, 1},
    '{2, 0, 1, 4, 1, 1}, '{1, 0, 0, 4, 1, 1}, '{2, 1, 0, 0, 1, 1},
    '{1, 0, 0, 0, 2, 1}, '{0, 0, 1, 0, 2, 2}};
  mem_ctrl_model model (.ref_clk(ref_clk), .memClk(memClk),
    .clkEnable(clkEnable), .cmdN(cmdN), .addrBit10(addrBit10),
    .bankAddr(bankAddr), .termEnable(termEnable));
  ddr2_refresh_powerdown_cmd dut (.ref_clk(ref_clk), .rst(rst),
    .memClk(memClk), .clkEnable(clkEnable), .csN(cmdN[3]),
    .rasN(cmdN[2]), .casN(cmdN[1]), .weN(cmdN[0]),
    .addrBit10(addrBit10), .bankAddr(bankAddr), .termEnable(termEnable),
    .fastExitMode(fastExitMode), .refreshStart(refreshStart),
    .refreshBusy(refreshBusy), .refreshBank(refreshBank),
    .refreshRow(refreshRow), .modeWrite(modeWrite),
    .modeSelect(modeSelect), .bankOpen(bankOpen), .burstBusy(burstBusy),
    .powerState(powerState), .buffersOn(buffersOn), .dllOn(dllOn),
    .freqChangeOk(freqChangeOk), .refreshOverdue(refreshOverdue),
    .readAllowed(readAllowed), .enableViolation(enableViolation));
  // Clock; pulses are counted since they stand for one cycle only
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    refs += (refreshStart === 1'b1);
    modes += (modeWrite === 1'b1);
    viols += (enableViolation === 1'b1);
    if (modeWrite === 1'b1)
      lastSel = modeSelect;
  end
  task automatic chk_val(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp)
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    miscompares += (got !== exp);
  endtask : chk_val
  task automatic chk_state(input ddr2_pd_pkg::pwr_state_type got, exp);
    chk_val(16'(got), 16'(exp));
  endtask : chk_state
  // Lets synchroniser and registered outputs land before sampling
  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #2;
  endtask : settle
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Hang guard
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    report_and_stop;
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    fastExitMode = 1'b0;
    repeat (10) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    chk_val({buffersOn, dllOn, readAllowed, bankOpen}, 16'h0070);
    foreach (rows[i])
    begin
      model.clk_cmd(rows[i].c, 1'b1, rows[i].a, rows[i].ba, 1);
      settle;
      chk_val(bankOpen, rows[i].open);
      chk_val(refs, rows[i].refs);
      chk_val(modes, rows[i].modes);
    end
    chk_val(lastSel, 1);
    chk_val({refreshRow, refreshBank}, 2);
    $display("command table done");
    // Mode set command time must run out before enable may drop
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 2);
    model.clk_cmd(4'h7, 1'b0, 1'b0, 2'h0, 3);
    settle;
    chk_state(powerState, ddr2_pd_pkg::PWR_PRECHARGE_DOWN);
    chk_val({buffersOn, dllOn, freqChangeOk}, 1);
    model.set_term(1'b1);
    settle;
    chk_val(freqChangeOk, 0);
    model.set_term(1'b0);
    model.clk_cmd(4'h3, 1'b0, 1'b0, 2'h0, 1);
    chk_val({bankOpen, refreshOverdue}, 0);
    repeat (1450) @(posedge ref_clk);
    #2;
    chk_val(refreshOverdue, 1);
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 3);
    settle;
    chk_state(powerState, ddr2_pd_pkg::PWR_RUN);
    $display("precharge power-down done");
    fastExitMode = 1'b1;
    model.clk_cmd(4'h3, 1'b1, 1'b0, 2'h0, 1);
    model.clk_cmd(4'h7, 1'b0, 1'b0, 2'h0, 3);
    settle;
    chk_state(powerState, ddr2_pd_pkg::PWR_ACTIVE_DOWN);
    chk_val({buffersOn, dllOn}, 1);
    fastExitMode = 1'b0;
    settle;
    chk_val(dllOn, 0);
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 3);
    model.clk_cmd(4'h5, 1'b1, 1'b0, 2'h0, 1);
    chk_val(burstBusy, 1);
    model.clk_cmd(4'h7, 1'b0, 1'b0, 2'h0, 3);
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 3);
    model.clk_cmd(4'h2, 1'b1, 1'b1, 2'h0, 1);
    settle;
    chk_val({bankOpen, burstBusy, 4'(viols)}, 16'h0001);
    $display("active power-down done");
    model.clk_cmd(4'h1, 1'b0, 1'b0, 2'h0, 3);
    settle;
    chk_state(powerState, ddr2_pd_pkg::PWR_SELF_REFRESH);
    model.pins(4'h7, 1'b1);
    settle;
    chk_state(powerState, ddr2_pd_pkg::PWR_RUN);
    chk_val(readAllowed, 0);
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 199);
    settle;
    chk_val(readAllowed, 0);
    model.clk_cmd(4'h7, 1'b1, 1'b0, 2'h0, 1);
    settle;
    chk_val(readAllowed, 1);
    $display("self refresh done");
    report_and_stop;
  end
endmodule : ddr2_refresh_powerdown_cmd_tb
bind ddr2_refresh_powerdown_cmd ddr2_refresh_powerdown_cmd_chk #(
  .BANKS(BANKS), .ROW_BITS(ROW_BITS)) chk (.ref_clk(ref_clk), .rst(rst),
  .fastExitMode(fastExitMode), .refreshStart(refreshStart),
  .refreshBusy(refreshBusy), .modeWrite(modeWrite),
  .refreshBank(refreshBank), .refreshRow(refreshRow),
  .bankOpen(bankOpen), .powerState(powerState), .buffersOn(buffersOn),
  .dllOn(dllOn), .freqChangeOk(freqChangeOk), .readAllowed(readAllowed));
`default_nettype wire
